/* rtl/fpc_pkg.sv */
/*
  package for the front panel control block: timing counts, filter level
  encodings and grouped carrier types.
  assumes a 40 MHz system clock.
*/
package fpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned FPC_CLK_HZ = 40000000;
  localparam int unsigned FPC_LOCKOUT_HOLD_S = 2;
  localparam int unsigned FPC_SIZE_IDLE_S = 8;
  localparam int unsigned FPC_BLINK_HALF_MS = 250;
  localparam int unsigned FPC_LOCKOUT_HOLD_CYC = FPC_CLK_HZ * FPC_LOCKOUT_HOLD_S;
  localparam int unsigned FPC_SIZE_IDLE_CYC = FPC_CLK_HZ * FPC_SIZE_IDLE_S;
  localparam int unsigned FPC_BLINK_HALF_CYC = (FPC_CLK_HZ / 1000) * FPC_BLINK_HALF_MS;

  ////////////////////////////////////////////////////////////////////////////
  // filter levels
  localparam logic [1:0] FPC_HORZ_LEVELS = 2'h2;
  localparam logic [1:0] FPC_VERT_LEVELS = 2'h3;
  localparam logic [1:0] FPC_ENC_LEVELS = 2'h3;
  localparam logic [1:0] FPC_LEVEL_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // carrier types
  typedef struct packed {
    logic freeze;
    logic size;
    logic horz_filt;
    logic vert_filt;
    logic enc_filt;
  } fpc_buttons_t;

  typedef struct packed {
    logic step_h;
    logic dir_h;
    logic step_v;
    logic dir_v;
  } fpc_knobs_t;

  typedef struct packed {
    logic amber;
    logic green;
  } fpc_power_led_t;

  typedef enum logic [1:0] {
    FPC_KNOB_CENTER = 2'b00,
    FPC_KNOB_PAN = 2'b01,
    FPC_KNOB_SIZE = 2'b10
  } fpc_knob_mode_t;

endpackage

/* rtl/fpc_level_sel.sv */
/*
  wrapping level selector: one step per pulse, shown one-hot.
  assumes the step input is a single-cycle pulse.
*/
`timescale 1ns/1ps
module fpc_level_sel
  import fpc_pkg::*;
#(
  parameter logic [1:0] LEVELS = 2'h3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control
  input wire logic step,
  // state
  output logic [1:0] level,
  output logic [2:0] level_led
);

  // step with wrap back to the first level
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      level <= FPC_LEVEL_RST;
    end else if (step) begin
      if (level == LEVELS - 2'h1) begin
        level <= FPC_LEVEL_RST; // [R19]
      end else begin
        level <= level + 2'h1;
      end
    end
  end

  // one-hot indicator, unused positions dark
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      level_led <= 3'h1;
    end else begin
      level_led <= 3'(3'h1 << level) & 3'((4'h1 << LEVELS) - 4'h1);
    end
  end

endmodule // fpc_level_sel

/* rtl/fpc_hold_timer.sv */
/*
  counts cycles while a level holds and pulses once on reaching the limit.
  assumes the hold input is synchronous to sys_clk.
*/
`timescale 1ns/1ps
module fpc_hold_timer #(
  parameter int unsigned LIMIT = 80000000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control
  input wire logic hold,
  // event
  output logic fire
);

  logic [31:0] count;
  logic done;

  // count while held, one pulse per hold
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count <= 32'h0;
      done <= 1'b0;
      fire <= 1'b0;
    end else if (!hold) begin
      count <= 32'h0;
      done <= 1'b0;
      fire <= 1'b0;
    end else if (!done && count == 32'(LIMIT - 1)) begin
      done <= 1'b1;
      fire <= 1'b1;
    end else begin
      fire <= 1'b0;
      if (!done) begin
        count <= count + 32'h1;
      end
    end
  end

endmodule // fpc_hold_timer

/* rtl/fpc_panel.sv */
/*
  front panel control: buttons, knobs, lockouts, filter levels and leds.
  assumes button and knob inputs are debounced, synchronous to sys_clk,
  and that remote commands arrive as single-cycle pulses.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - Power led steady amber when powered with no input signal.
// R2 - Power led blinks green when input resolution is out of range.
// R3 - In range, power led blinks green while infrared commands arrive.
// R4 - Power led steady green when input in range and locked.
// R5 - Freeze button toggles freeze; freeze led and frozen outputs follow.
// R6 - Freeze active blocks all panel and infrared controls except freeze.
// R7 - Freeze plus size held two seconds enters panel lockout, centering still works.
// R8 - Same two-second hold in lockout leaves it.
// R9 - Panel lockout never blocks serial or infrared adjustments.
// R10 - Horizontal filter button steps between two levels, yellow leds show it.
// R11 - Vertical filter button steps through three levels, yellow leds show it.
// R12 - Encoder filter button steps through three levels, yellow leds show it.
// R13 - Size button starts size mode, green led, knobs change picture size.
// R14 - Size mode ends eight seconds after last knob activity.
// R15 - Size button during size mode ends size mode.
// R16 - Outside size mode knobs center if picture fits, else pan.
// R17 - Limit led red while a knob adjustment sits at min or max.
// R18 - Reference lock led green while valid black burst is received.
// R19 - Filter selection wraps to the first level after the last.
module fpc_panel
  import fpc_pkg::*;
#(
  parameter int unsigned LOCKOUT_HOLD_CYC = FPC_LOCKOUT_HOLD_CYC,
  parameter int unsigned SIZE_IDLE_CYC = FPC_SIZE_IDLE_CYC,
  parameter int unsigned BLINK_HALF_CYC = FPC_BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // front panel
  input wire fpc_buttons_t btn,
  input wire fpc_knobs_t knob,
  // infrared remote, one-cycle command pulses
  input wire fpc_buttons_t ir_cmd,
  input wire logic ir_active,
  // serial remote, one-cycle command pulses
  input wire fpc_buttons_t ser_cmd,
  // video status
  input wire logic sig_present,
  input wire logic sig_in_range,
  input wire logic sig_locked,
  input wire logic pic_oversize,
  input wire logic adj_at_limit,
  input wire logic ref_valid,
  // settings out
  output logic freeze_on,
  output logic size_on,
  output logic lockout_on,
  output logic [1:0] horz_level,
  output logic [1:0] vert_level,
  output logic [1:0] enc_level,
  output fpc_knob_mode_t knob_mode,
  output fpc_knobs_t knob_adj,
  // indicators
  output fpc_power_led_t power_led,
  output logic freeze_led,
  output logic size_led,
  output logic [2:0] horz_led,
  output logic [2:0] vert_led,
  output logic [2:0] enc_led,
  output logic limit_led,
  output logic ref_led
);

  fpc_buttons_t btn_q;
  fpc_buttons_t btn_rise;
  fpc_buttons_t panel_ok;
  fpc_buttons_t remote_ok;
  fpc_buttons_t act;
  logic combo;
  logic combo_fire;
  logic combo_seen;
  logic knob_any;
  logic [31:0] idle_count;
  logic [31:0] blink_count;
  logic blink;

  //////////////////////////////////////////////////////////////////////////////
  // button edge detection
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      btn_q <= '0;
    end else begin
      btn_q <= btn;
    end
  end

  assign combo = btn.freeze & btn.size;

  // a press that forms part of the two-button hold never acts; only clean
  // single presses; freeze and size releases are gated from both down until both are up
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      combo_seen <= 1'b0;
    end else if (combo) begin
      combo_seen <= 1'b1;
    end else if (!btn.freeze && !btn.size) begin
      combo_seen <= 1'b0;
    end
  end

  // freeze and size act on release so the two-button hold toggles nothing
  assign btn_rise.freeze = btn_q.freeze & ~btn.freeze & ~combo_seen;
  assign btn_rise.size = btn_q.size & ~btn.size & ~combo_seen;
  assign btn_rise.horz_filt = btn.horz_filt & ~btn_q.horz_filt;
  assign btn_rise.vert_filt = btn.vert_filt & ~btn_q.vert_filt;
  assign btn_rise.enc_filt = btn.enc_filt & ~btn_q.enc_filt;

  //////////////////////////////////////////////////////////////////////////////
  // control gating
  always_comb begin
    panel_ok = btn_rise;
    remote_ok = ir_cmd | ser_cmd; // [R9]
    if (lockout_on) begin
      panel_ok = '0; // [R7]
    end
    if (freeze_on) begin
      panel_ok = '0; // [R6]
      remote_ok = '0;
      panel_ok.freeze = btn_rise.freeze & ~lockout_on;
      remote_ok.freeze = ir_cmd.freeze | ser_cmd.freeze;
    end
    act = panel_ok | remote_ok;
  end

  //////////////////////////////////////////////////////////////////////////////
  // freeze toggle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      freeze_on <= 1'b0;
    end else if (act.freeze) begin
      freeze_on <= ~freeze_on; // [R5]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // panel lockout by two-button hold
  fpc_hold_timer #(
    .LIMIT(LOCKOUT_HOLD_CYC)
  ) u_hold (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .hold(combo),
    .fire(combo_fire)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lockout_on <= 1'b0;
    end else if (combo_fire) begin
      lockout_on <= ~lockout_on; // [R7] [R8]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // filter selectors
  fpc_level_sel #(
    .LEVELS(FPC_HORZ_LEVELS)
  ) u_horz (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .step(act.horz_filt), // [R10]
    .level(horz_level),
    .level_led(horz_led)
  );

  fpc_level_sel #(
    .LEVELS(FPC_VERT_LEVELS)
  ) u_vert (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .step(act.vert_filt), // [R11]
    .level(vert_level),
    .level_led(vert_led)
  );

  fpc_level_sel #(
    .LEVELS(FPC_ENC_LEVELS)
  ) u_enc (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .step(act.enc_filt), // [R12]
    .level(enc_level),
    .level_led(enc_led)
  );

  //////////////////////////////////////////////////////////////////////////////
  // knobs: panel knobs blocked by freeze, never by lockout
  assign knob_any = (knob.step_h | knob.step_v) & ~freeze_on; // [R6] [R7]

  // size mode with inactivity timeout
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      size_on <= 1'b0;
      idle_count <= 32'h0;
    end else if (act.size) begin
      size_on <= ~size_on; // [R13] [R15]
      idle_count <= 32'h0;
    end else if (size_on) begin
      if (knob_any) begin
        idle_count <= 32'h0;
      end else if (idle_count == 32'(SIZE_IDLE_CYC - 1)) begin
        size_on <= 1'b0; // [R14]
        idle_count <= 32'h0;
      end else begin
        idle_count <= idle_count + 32'h1;
      end
    end else begin
      idle_count <= 32'h0;
    end
  end

  // knob routing
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      knob_mode <= FPC_KNOB_CENTER;
      knob_adj <= '0;
    end else begin
      if (size_on) begin
        knob_mode <= FPC_KNOB_SIZE; // [R13]
      end else if (pic_oversize) begin
        knob_mode <= FPC_KNOB_PAN; // [R16]
      end else begin
        knob_mode <= FPC_KNOB_CENTER; // [R16]
      end
      knob_adj <= freeze_on ? '0 : knob; // [R6]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // blink timebase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      blink_count <= 32'h0;
      blink <= 1'b0;
    end else if (blink_count == 32'(BLINK_HALF_CYC - 1)) begin
      blink_count <= 32'h0;
      blink <= ~blink;
    end else begin
      blink_count <= blink_count + 32'h1;
    end
  end

  // power and lock indicator
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      power_led <= '{amber: 1'b1, green: 1'b0};
    end else if (!sig_present) begin
      power_led <= '{amber: 1'b1, green: 1'b0}; // [R1]
    end else if (!sig_in_range) begin
      power_led <= '{amber: 1'b0, green: blink}; // [R2]
    end else if (ir_active) begin
      power_led <= '{amber: 1'b0, green: blink}; // [R3]
    end else begin
      power_led <= '{amber: 1'b0, green: sig_locked}; // [R4]
    end
  end

  // mode and status indicators
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      freeze_led <= 1'b0;
      size_led <= 1'b0;
      limit_led <= 1'b0;
      ref_led <= 1'b0;
    end else begin
      freeze_led <= freeze_on; // [R5]
      size_led <= size_on; // [R13]
      limit_led <= adj_at_limit; // [R17]
      ref_led <= ref_valid; // [R18]
    end
  end

endmodule // fpc_panel

/* bench/fpc_panel_properties.sv */
/* checker on the panel ports, bound into fpc_panel.
   assumes one clock and an async active-low reset. */
`timescale 1ns/1ps
module fpc_panel_properties
  import fpc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // inputs
  input wire fpc_buttons_t ser_cmd,
  input wire logic ir_active,
  input wire logic sig_present,
  input wire logic sig_in_range,
  input wire logic sig_locked,
  input wire logic adj_at_limit,
  input wire logic ref_valid,
  // outputs
  input wire logic freeze_on,
  input wire logic size_on,
  input wire logic lockout_on,
  input wire logic [1:0] horz_level,
  input wire logic [1:0] vert_level,
  input wire logic [1:0] enc_level,
  input wire fpc_power_led_t power_led,
  input wire logic freeze_led,
  input wire logic size_led,
  input wire logic [2:0] horz_led,
  input wire logic limit_led,
  input wire logic ref_led
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // remote filter steps and wrap
  horz_step_a: assert property (ser_cmd.horz_filt && !freeze_on |=> horz_level == ($past(horz_level) == 2'h1 ? 2'h0 : 2'h1))
    else $error("horizontal filter step wrong");
  vert_step_a: assert property (ser_cmd.vert_filt && !freeze_on |=> vert_level == ($past(vert_level) == 2'h2 ? 2'h0 : $past(vert_level) + 2'h1))
    else $error("vertical filter step wrong");
  enc_step_a: assert property (ser_cmd.enc_filt && !freeze_on |=> enc_level == ($past(enc_level) == 2'h2 ? 2'h0 : $past(enc_level) + 2'h1))
    else $error("encoder filter step wrong");
  // indicators follow state; settings hold while frozen, serial steps pass lockout
  horz_led_a: assert property (1'b1 |=> horz_led == 3'h1 << $past(horz_level))
    else $error("horizontal leds disagree");
  freeze_led_a: assert property (1'b1 |=> freeze_led == $past(freeze_on))
    else $error("freeze led disagrees");
  size_led_a: assert property (1'b1 |=> size_led == $past(size_on))
    else $error("size led disagrees");
  frozen_hold_a: assert property (freeze_on |=> $stable({horz_level, vert_level, enc_level}))
    else $error("setting moved while frozen");
  limit_led_a: assert property (1'b1 |=> limit_led == $past(adj_at_limit))
    else $error("limit led wrong");
  ref_led_a: assert property (1'b1 |=> ref_led == $past(ref_valid))
    else $error("reference led wrong");
  no_sig_a: assert property (!sig_present |=> power_led == 2'b10)
    else $error("power led not amber");
  locked_a: assert property (sig_present && sig_in_range && sig_locked && !ir_active |=> power_led == 2'b01)
    else $error("power led not steady green");
  lock_ser_a: assert property (lockout_on && ser_cmd.enc_filt && !freeze_on |=> enc_level != $past(enc_level))
    else $error("serial blocked by lockout");
  // main scenarios
  cover property ($rose(lockout_on));
  cover property ($fell(size_on));
  cover property ($rose(freeze_on));
endmodule // fpc_panel_properties

bind fpc_panel fpc_panel_properties u_fpc_panel_properties (.sys_clk, .rstn, .ser_cmd, .ir_active, .sig_present,
  .sig_in_range, .sig_locked, .adj_at_limit, .ref_valid, .freeze_on, .size_on, .lockout_on, .horz_level,
  .vert_level, .enc_level, .power_led, .freeze_led, .size_led, .horz_led, .limit_led, .ref_led);

/* bench/fpc_operator.sv */
/* operator model: holds a chosen set of panel buttons for a set time.
   assumes the bench clock and reset. */
`timescale 1ns/1ps
module fpc_operator
  import fpc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // request
  input wire logic go,
  input wire fpc_buttons_t press,
  input wire logic [7:0] hold,
  // panel
  output fpc_buttons_t btn
);
  logic [7:0] cnt;
  // press, hold, then release all together
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      btn <= '0;
      cnt <= 8'h00;
    end else if (go) begin
      btn <= press;
      cnt <= hold;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) btn <= '0;
    end
  end
endmodule // fpc_operator

/* bench/tb_front_panel_control_logic.sv */
/* bench for fpc_panel: operator model on the buttons, remote pulses, status.
   assumes shortened hold and idle counts. */
`timescale 1ns/1ps
module tb_front_panel_control_logic;
  import fpc_pkg::*;
  logic sys_clk, rstn, go, ir_active, sig_present, sig_in_range, sig_locked, pic_oversize, adj_at_limit, ref_valid;
  logic [7:0] hold;
  logic [15:0] r;
  fpc_buttons_t pb, btn, ir_cmd, ser_cmd;
  fpc_knobs_t knob, knob_adj;
  logic freeze_on, size_on, lockout_on, freeze_led, size_led, limit_led, ref_led;
  logic [1:0] horz_level, vert_level, enc_level;
  logic [2:0] horz_led, vert_led, enc_led;
  fpc_knob_mode_t knob_mode;
  fpc_power_led_t power_led;
  int n_mismatch = 0, checks = 0, mh = 0, mv = 0, me = 0, mf = 0, ms = 0, ml = 0, ng = 0, na = 0;
  fpc_operator u_fpc_operator (.sys_clk, .rstn, .go, .press(pb), .hold, .btn);
  fpc_panel #(.LOCKOUT_HOLD_CYC(20), .SIZE_IDLE_CYC(50), .BLINK_HALF_CYC(8)) u_fpc_panel (.sys_clk, .rstn, .btn,
    .knob, .ir_cmd,
    .ir_active, .ser_cmd, .sig_present, .sig_in_range, .sig_locked, .pic_oversize, .adj_at_limit, .ref_valid,
    .freeze_on, .size_on, .lockout_on, .horz_level, .vert_level, .enc_level, .knob_mode, .knob_adj, .power_led,
    .freeze_led, .size_led, .horz_led, .vert_led, .enc_led, .limit_led, .ref_led);
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic push(input fpc_buttons_t b, input logic [7:0] n);
    @(posedge sys_clk) begin go <= 1'b1; pb <= b; hold <= n; end
    @(posedge sys_clk) go <= 1'b0;
    repeat (n + 8) @(posedge sys_clk);
  endtask
  task automatic pulse(input logic ir, input fpc_buttons_t b);
    @(posedge sys_clk) if (ir) ir_cmd <= b; else ser_cmd <= b;
    @(posedge sys_clk) begin ir_cmd <= '0; ser_cmd <= '0; end
    repeat (3) @(posedge sys_clk);
  endtask
  // model filter step when neither lockout nor freeze blocks it
  task automatic step(input int k, input logic remote);
    if (!mf && (remote || !ml)) begin
      if (k == 0) mh = (mh + 1) % 2;
      if (k == 1) mv = (mv + 1) % 3;
      if (k == 2) me = (me + 1) % 3;
    end
  endtask
  task automatic check_all();
    chk(4'(horz_level), 4'(mh));
    chk(4'(vert_level), 4'(mv));
    chk(4'(enc_level), 4'(me));
    chk({horz_led, 1'b0}, 4'(2 << mh));
    chk({vert_led, 1'b0}, 4'(2 << mv));
    chk({enc_led, 1'b0}, 4'(2 << me));
    chk({freeze_on, freeze_led, size_on, size_led}, 4'(mf * 12 + ms * 3));
    chk(4'(lockout_on), 4'(ml));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock, watchdog, main sequence
  initial begin sys_clk = 1'b0; forever #12.5 sys_clk = ~sys_clk; end
  initial begin #1000000; n_mismatch++; conclude(); end
  initial begin
    {rstn, go, ir_active, sig_present, sig_in_range, sig_locked, pic_oversize, adj_at_limit, ref_valid} = '0;
    {pb, ir_cmd, ser_cmd, knob, hold} = '0;
    r = 16'h46FF;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 21; i++) begin
      push(5'h04 >> (i % 3), 8'h02);
      step(i % 3, 1'b0);
      check_all();
    end
    $display("filter test done");
    push(5'h10, 8'h02);
    mf = 1;
    // knob steps must not pass while frozen
    @(posedge sys_clk) knob <= 4'hF;
    @(posedge sys_clk) knob <= 4'h0;
    @(negedge sys_clk) chk(knob_adj, 4'h0);
    push(5'h04, 8'h02);
    pulse(1'b0, 5'h02);
    check_all();
    pulse(1'b1, 5'h10);
    mf = 0;
    check_all();
    $display("freeze test done");
    push(5'h18, 8'd25);
    ml = 1;
    push(5'h04, 8'h02);
    pulse(1'b0, 5'h01);
    step(2, 1'b1);
    check_all();
    push(5'h18, 8'd25);
    ml = 0;
    check_all();
    $display("lockout test done");
    push(5'h08, 8'h02);
    ms = 1;
    chk(4'(knob_mode), 4'(FPC_KNOB_SIZE));
    repeat (3) begin
      repeat (30) @(posedge sys_clk);
      @(posedge sys_clk) knob <= 4'hA;
      @(posedge sys_clk) knob <= 4'h0;
      @(negedge sys_clk) chk(knob_adj, 4'hA);
    end
    check_all();
    repeat (60) @(posedge sys_clk);
    ms = 0;
    check_all();
    chk(4'(knob_mode), 4'(FPC_KNOB_CENTER));
    @(posedge sys_clk) pic_oversize <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(4'(knob_mode), 4'(FPC_KNOB_PAN));
    push(5'h08, 8'h02);
    ms = 1;
    check_all();
    push(5'h08, 8'h02);
    ms = 0;
    check_all();
    $display("size test done");
    repeat (64) begin
      r = lfsr(r);
      @(posedge sys_clk) {sig_present, sig_in_range, sig_locked, ir_active, adj_at_limit, ref_valid} <= r[5:0];
      repeat (2) @(posedge sys_clk);
      chk({limit_led, ref_led}, r[1:0]);
      if (!r[5]) chk(4'(power_led), 4'h2);
      if (r[5:2] == 4'hE) chk(4'(power_led), 4'h1);
    end
    $display("status test done");
    // green blinks half the time: bad range first, then infrared activity in range
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk) {sig_present, sig_in_range, sig_locked, ir_active} <= {1'b1, k[0], 1'b1, k[0]};
      repeat (3) @(posedge sys_clk);
      ng = 0;
      na = 0;
      repeat (16) begin
        @(negedge sys_clk);
        ng += power_led.green;
        na += power_led.amber;
      end
      chk(4'(ng), 4'h8);
      chk(4'(na), 4'h0);
    end
    $display("blink test done");
    // reset in mid-run returns every setting to its first state
    @(posedge sys_clk) rstn <= 1'b0;
    {mh, mv, me, mf, ms, ml} = '0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) check_all();
    chk(4'(power_led), 4'h2);
    chk(4'(knob_mode), 4'(FPC_KNOB_CENTER));
    @(posedge sys_clk) rstn <= 1'b1;
    push(5'h02, 8'h02);
    step(1, 1'b0);
    check_all();
    $display("reset test done");
    conclude();
  end
endmodule // tb_front_panel_control_logic
